/* hdl/rcs_exec.sv */
// Purpose: Executes the relative subroutine call and the software reset instruction
// Assumes: Phase counter free-runs Q1..Q4; the instruction word is stable during a cycle
// Notes:   The reset controller owns the actual master clear sequence
//
// What this block does
// - Push return address before changing program counter
// - Target is incremented PC plus doubled offset
// - Eleven-bit offset limits reach to about 1K
// - Call takes two cycles, second is no-op
// - Software reset acts like master clear reset
// - Reset opcode is 0x00FF exactly
// - Reset decodes Q1, starts Q2, then idles
`timescale 1ns/1ps
module rcs_exec
  import rcs_pkg::*;
(
  input  wire logic              i_clock,         // Phase clock, four edges per cycle
  input  wire logic              i_rst_n,         // Asynchronous active-low reset
  input  wire logic [15:0]       i_instr,         // Instruction being executed
  input  wire logic              i_instr_valid,   // Instruction word is meaningful
  input  wire logic [PC_W-1:0]   i_pc_inc,        // Program counter already advanced
  output rcs_push_s              o_push,          // Return stack push request
  output rcs_pcload_s            o_pc_load,       // Program counter load request
  output logic                   o_flush,         // Pipeline refill, force no-op
  output logic [15:0]            o_exec_word,     // Word really executed this cycle
  output logic                   o_master_clear_reset, // Request to reset controller
  output logic [3:0]             o_phase          // Current phase, one-hot
);

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencer
  ////////////////////////////////////////////////////////////////////////////
  rcs_phase_e phase_q;   // Current phase
  rcs_phase_e phase_d;   // Next phase

  // Phase advance, wraps after the fourth phase
  always_comb begin
    case (phase_q)
      RCS_Q1:  phase_d = RCS_Q2;
      RCS_Q2:  phase_d = RCS_Q3;
      RCS_Q3:  phase_d = RCS_Q4;
      RCS_Q4:  phase_d = RCS_Q1;
      default: phase_d = RCS_Q1;
    endcase
  end

  // Phase register
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_q <= RCS_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign o_phase = phase_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  ////////////////////////////////////////////////////////////////////////////
  logic            refill_q;    // Current cycle is the dead call cycle
  logic            refill_d;    // Next value of refill flag
  logic            is_call;     // Call opcode present and executable
  logic            is_srst;     // Software reset opcode present
  logic [PC_W-1:0] target;      // Computed destination
  logic [PC_W-1:0] ret_q;       // Latched return address
  logic [PC_W-1:0] tgt_q;       // Latched destination

  // call prefix decode
  // A word in the refill slot is discarded, so it can never start a call
  assign is_call = i_instr_valid && !refill_q && (i_instr[15:11] == CALL_PREFIX);

  assign is_srst = i_instr_valid && !refill_q && (i_instr == SOFT_RST_OP);

  // eleven-bit offset width bounds reach
  // Offset field is exactly eleven bits: -1024..1023 words
  rcs_target_calc u_calc (
    .i_pc_inc (i_pc_inc),
    .i_offset (i_instr[OFS_W-1:0]),
    .o_target (target)
  );

  // Capture return address and destination while reading the literal
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ret_q <= PC_RESET;
      tgt_q <= PC_RESET;
    end else if (phase_q == RCS_Q1 && is_call) begin
      ret_q <= i_pc_inc;
      tgt_q <= target;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Call sequencing
  ////////////////////////////////////////////////////////////////////////////
  logic call_act_q;   // A call is executing in the current cycle

  // Track that a call was decoded in this cycle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      call_act_q <= 1'b0;
    end else if (phase_q == RCS_Q1) begin
      call_act_q <= is_call;
    end
  end

  // push in Q2
  // Push happens in Q2, strictly before the Q4 program counter write
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_push <= '0;
    end else begin
      o_push.push <= (phase_q == RCS_Q1) && is_call;
      o_push.addr <= ((phase_q == RCS_Q1) && is_call) ? i_pc_inc : ret_q;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pc_load <= '0;
    end else begin
      o_pc_load.load <= (phase_q == RCS_Q3) && call_act_q;
      o_pc_load.addr <= tgt_q;
    end
  end

  // second cycle no-op
  // Refill flag set at cycle end after a call, kept for one full cycle
  always_comb begin
    refill_d = refill_q;
    if (phase_q == RCS_Q4) begin
      refill_d = call_act_q;
    end
  end

  // Refill flag register
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      refill_q <= 1'b0;
    end else begin
      refill_q <= refill_d;
    end
  end

  assign o_flush = refill_q;

  // forced no-op word
  // The stale prefetched word must not reach the datapath
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_exec_word <= NOP_WORD;
    end else if (phase_q == RCS_Q4) begin
      o_exec_word <= refill_d ? NOP_WORD : i_instr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software reset
  ////////////////////////////////////////////////////////////////////////////

  // same master clear path
  // One phase pulse drives the same request the external pin uses
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_master_clear_reset <= 1'b0;
    end else begin
      o_master_clear_reset <= (phase_q == RCS_Q1) && is_srst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////////////
  sequence s_call_decode;
    phase_q == RCS_Q1 && is_call;
  endsequence

  sequence s_push_then_load;
    o_push.push ##2 o_pc_load.load;
  endsequence

  chk_push_before_load: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    s_call_decode |=> s_push_then_load)
    else $error("Push not followed by PC load two phases later");

  chk_push_ret_addr: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    s_call_decode |=> o_push.addr == $past(i_pc_inc))
    else $error("Pushed address is not incremented PC");

  // Expected target rebuilt from the input word, independent of the adder
  chk_target_value: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    s_call_decode |=> ##2 o_pc_load.addr == $past(i_pc_inc, 3)
      + {{(PC_W-OFS_W-1){$past(i_instr[OFS_W-1], 3)}}, $past(i_instr[OFS_W-1:0], 3), 1'b0})
    else $error("Loaded target mismatch");

  chk_offset_reach: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    is_call |-> (target - i_pc_inc + 21'h000800) <= 21'h000FFE)
    else $error("Call target outside reach");

  chk_refill_cycle: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    s_call_decode |=> ##3 (o_flush && o_exec_word == NOP_WORD) [*4])
    else $error("Second call cycle not a no-op");

  chk_no_call_refill: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    refill_q |-> !o_push.push && !$rose(o_pc_load.load))
    else $error("Activity during refill cycle");

  chk_reset_opcode: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    o_master_clear_reset |-> $past(i_instr) == SOFT_RST_OP)
    else $error("Reset raised without reset opcode");

  chk_reset_phase: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    o_master_clear_reset |-> phase_q == RCS_Q2 ##1 !o_master_clear_reset [*2])
    else $error("Reset request not a Q2 single pulse");

  chk_reset_request: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (phase_q == RCS_Q1 && is_srst) |=> o_master_clear_reset)
    else $error("Software reset did not request master clear");

endmodule : rcs_exec

/* include/rcs_pkg.sv */
// Purpose: Shared constants and carriers for the relative call and soft reset executor
// Assumes: Byte-addressed program counter, 16-bit instruction words
// Notes:   Phase codes follow the four-phase instruction cycle
package rcs_pkg;

  localparam int          PC_W          = 21;            // Program counter width
  localparam int          OFS_W         = 11;            // Signed word offset width
  localparam logic [4:0]  CALL_PREFIX   = 5'h1B;         // Upper five opcode bits of the call
  localparam logic [15:0] SOFT_RST_OP   = 16'h00FF;      // Software reset opcode
  localparam logic [15:0] NOP_WORD      = 16'hF000;      // Word forced while refilling
  localparam logic [PC_W-1:0] PC_RESET  = 21'h000000;    // Program counter after reset
  localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;    // Bytes per instruction word
  localparam int          RST_PULSE_CYC = 1;             // Reset request length in phases

  // One-hot phase codes
  typedef enum logic [3:0] {
    RCS_Q1 = 4'h1,
    RCS_Q2 = 4'h2,
    RCS_Q3 = 4'h4,
    RCS_Q4 = 4'h8
  } rcs_phase_e;

  // Return stack push request
  typedef struct packed {
    logic            push;
    logic [PC_W-1:0] addr;
  } rcs_push_s;

  // Program counter load request
  typedef struct packed {
    logic            load;
    logic [PC_W-1:0] addr;
  } rcs_pcload_s;

endpackage : rcs_pkg

/* hdl/rcs_target_calc.sv */
// Purpose: Computes the relative call target from the incremented program counter
// Assumes: Offset is an eleven-bit two's complement word count
// Notes:   Purely combinational, result is registered by the caller
`timescale 1ns/1ps
module rcs_target_calc
  import rcs_pkg::*;
(
  input  wire logic [PC_W-1:0]  i_pc_inc,   // Already incremented program counter
  input  wire logic [OFS_W-1:0] i_offset,   // Encoded signed word offset
  output logic      [PC_W-1:0]  o_target    // Call destination
);

  logic [PC_W-1:0] byte_ofs;  // Sign extended and doubled offset

  // doubled signed offset
  // Sign extension first, then shift, so negative offsets stay negative
  always_comb begin
    byte_ofs = {{(PC_W-OFS_W-1){i_offset[OFS_W-1]}}, i_offset, 1'b0};
    o_target = i_pc_inc + byte_ofs;
  end

endmodule : rcs_target_calc

/* dv/test_rcs_exec.sv */
// Purpose: Self-checking bench for the relative call and soft reset executor
// Assumes: One rising edge per phase; inputs change on the falling edge
// Notes:   Checks run at the falling edge, once each phase has settled
`timescale 1ns/1ps
module test_rcs_exec;
  import rcs_pkg::*;

  logic              i_clock;              // Phase clock
  logic              i_rst_n;              // Master clear, active low
  logic [15:0]       i_instr;              // Instruction word
  logic              i_instr_valid;        // Word is executable
  logic [PC_W-1:0]   i_pc_inc;             // Incremented program counter
  rcs_push_s         o_push;               // Return stack push
  rcs_pcload_s       o_pc_load;            // Program counter load
  logic              o_flush;              // Refill in progress
  logic [15:0]       o_exec_word;          // Word executed
  logic              o_master_clear_reset; // Soft reset request
  logic [3:0]        o_phase;              // One-hot phase
  int                num_errors;           // Mismatch count
  int                checked;              // Comparison count

  rcs_exec i_dut (
    .i_clock              (i_clock),
    .i_rst_n              (i_rst_n),
    .i_instr              (i_instr),
    .i_instr_valid        (i_instr_valid),
    .i_pc_inc             (i_pc_inc),
    .o_push               (o_push),
    .o_pc_load            (o_pc_load),
    .o_flush              (o_flush),
    .o_exec_word          (o_exec_word),
    .o_master_clear_reset (o_master_clear_reset),
    .o_phase              (o_phase)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock: 5 ns period, one phase per period
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  // Case equality so an unknown never passes
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Present a word in Q1; bounded wait so a stuck phase cannot hang us
  task automatic issue(input logic [15:0] w, input logic v, input logic [PC_W-1:0] pc);
    int n;
    n = 0;
    while (o_phase !== 4'h1 && n < 8) begin
      @(negedge i_clock);
      n++;
    end
    i_instr       = w;
    i_instr_valid = v;
    i_pc_inc      = pc;
  endtask : issue

  ////////////////////////////////////////////////////////////////////////////////
  // Call walk, with a soft reset word slipped into the refill cycle
  task automatic run_call(input logic [OFS_W-1:0] ofs, input logic [PC_W-1:0] pc);
    logic [PC_W-1:0] exp;
    exp = pc + {{9{ofs[10]}}, ofs, 1'b0};
    issue({CALL_PREFIX, ofs}, 1'b1, pc);
    @(negedge i_clock);
    chk("phase", o_phase, RCS_Q2);
    chk("push", o_push.push, 1'h1);
    chk("push_addr", o_push.addr, pc);
    chk("load_early", o_pc_load.load, 1'h0);
    @(negedge i_clock);
    chk("push_len", o_push.push, 1'h0);
    @(negedge i_clock);
    chk("load", o_pc_load.load, 1'h1);
    chk("target", o_pc_load.addr, exp);
    @(negedge i_clock);
    chk("load_len", o_pc_load.load, 1'h0);
    chk("flush", o_flush, 1'h1);
    chk("exec_nop", o_exec_word, NOP_WORD);
    i_instr = SOFT_RST_OP;
    @(negedge i_clock);
    chk("refill_push", o_push.push, 1'h0);
    chk("refill_clr", o_master_clear_reset, 1'h0);
    repeat (3) @(negedge i_clock);
    chk("flush_end", o_flush, 1'h0);
    i_instr_valid = 1'b0;
  endtask : run_call

  // One-cycle word: reset pulse only for the exact opcode, nothing else moves
  task automatic run_word(input logic [15:0] w, input logic v, input logic exp);
    issue(w, v, 21'h000100);
    @(negedge i_clock);
    chk("clr_pulse", o_master_clear_reset, exp);
    chk("word_push", o_push.push, 1'h0);
    @(negedge i_clock);
    chk("clr_len", o_master_clear_reset, 1'h0);
    @(negedge i_clock);
    @(negedge i_clock);
    chk("word_load", o_pc_load.load, 1'h0);
    if (v) chk("exec_word", o_exec_word, w);
    i_instr_valid = 1'b0;
  endtask : run_word

  // Master clear in the middle of a call: state drops, no late PC load follows
  task automatic run_mid_reset;
    issue({CALL_PREFIX, 11'h005}, 1'b1, 21'h000300);
    @(negedge i_clock);
    chk("mr_push", o_push.push, 1'h1);
    // Word withdrawn so the first Q1 after release starts nothing
    i_rst_n       = 1'b0;
    i_instr_valid = 1'b0;
    @(negedge i_clock);
    chk("mr_phase", o_phase, RCS_Q1);
    chk("mr_push_clr", o_push.push, 1'h0);
    chk("mr_flush", o_flush, 1'h0);
    chk("mr_exec", o_exec_word, NOP_WORD);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clock);
    chk("mr_no_load", o_pc_load.load, 1'h0);
    @(negedge i_clock);
  endtask : run_mid_reset

  // Verdict and end of run, shared with the watchdog
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    num_errors    = 0;
    checked       = 0;
    i_rst_n       = 1'b0;
    i_instr       = NOP_WORD;
    i_instr_valid = 1'b0;
    i_pc_inc      = PC_RESET;
    repeat (8) @(negedge i_clock);
    chk("rst_phase", o_phase, RCS_Q1);
    chk("rst_exec", o_exec_word, NOP_WORD);
    i_rst_n = 1'b1;
    // offsets at both ends of reach
    run_call(11'h000, 21'h000200);
    run_call(11'h7FF, 21'h000200);
    run_call(11'h3FF, 21'h000010);
    run_call(11'h400, 21'h000010);
    run_call(11'h400, 21'h1FFF00);
    run_mid_reset();
    run_call(11'h001, 21'h000040);
    // exact opcode, back to back, then near misses
    run_word(SOFT_RST_OP, 1'b1, 1'b1);
    run_word(SOFT_RST_OP, 1'b1, 1'b1);
    run_word(16'h01FF, 1'b1, 1'b0);
    run_word(16'h00FE, 1'b1, 1'b0);
    run_word(SOFT_RST_OP, 1'b0, 1'b0);
    run_word(16'hD3FF, 1'b1, 1'b0);
    run_word(16'hE3FF, 1'b1, 1'b0);
    test_done();
  end

  // Watchdog: run needs about 90 phases
  initial begin
    #(2000 * 5);
    num_errors++;
    test_done();
  end

endmodule : test_rcs_exec
